// *** flash_byte_array.sv ***
// Byte-wide array memory with a registered read port and a preload port.
`timescale 1ns/1ps
`default_nettype none

module flash_byte_array #(
  parameter int ADDR_W = 22
) (
  input wire logic clock_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [ADDR_W-1:0] raddr_i,
  output logic [7:0] rdata_o
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [7:0] mem_q [2**ADDR_W];

  // Preload writes and the read register share one clock; read data lag one cycle.
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end

endmodule : flash_byte_array
`default_nettype wire

// *** flash_read_monitor.sv ***
// Port-level checks for the multi-line flash read path.
`timescale 1ns/1ps
`default_nettype none

module flash_read_monitor (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire multi_io_pkg::spi_in_t pins_i,
  input wire multi_io_pkg::spi_out_t pins_o,
  input wire logic cont_mode_o,
  input wire logic [2:0] wrap_setting_bits_o
);
  // Every check samples on the system clock and rests while reset is low.
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // Between frames the lines are released and the stored settings hold; lane enables always form one legal pattern.
  cs_release_a: assert property (
    pins_i.cs_n [*5] |-> pins_o.io_oe_n == 4'hf)
    else $error("lines driven with chip select high");
  mode_idle_a: assert property (
    pins_i.cs_n [*5] |=> $stable(cont_mode_o))
    else $error("continuous mode moved between frames");
  wrap_idle_a: assert property (
    pins_i.cs_n [*5] |=> $stable(wrap_setting_bits_o))
    else $error("wrap setting moved between frames");
  lane_set_a: assert property (
    pins_o.io_oe_n inside {4'hf, 4'hc, 4'h0})
    else $error("illegal lane enable pattern");

  // The wrap setting changes and continuous mode sets on a clock rise, outputs move only after a clock fall.
  wrap_write_a: assert property (
    $changed(wrap_setting_bits_o) |-> !pins_i.cs_n && $past(pins_i.sclk, 2))
    else $error("wrap setting changed away from a clock rise");
  mode_set_a: assert property (
    $rose(cont_mode_o) |-> !pins_i.cs_n && $past(pins_i.sclk, 2))
    else $error("continuous mode set away from a clock rise");
  data_hold_a: assert property (
    !pins_i.cs_n && pins_i.sclk && $past(pins_i.sclk) |=> $stable(pins_o.io))
    else $error("data changed while the clock was high");
  drive_start_a: assert property (
    $fell(pins_o.io_oe_n[0]) |-> $past(pins_i.sclk, 5) && !$past(pins_i.sclk, 2))
    else $error("drive began away from a clock fall");

  // Main scenarios seen at least once.
  cover property ($rose(cont_mode_o));
  cover property ($changed(wrap_setting_bits_o));
  cover property (pins_o.io_oe_n == 4'h0);
endmodule : flash_read_monitor
`default_nettype wire

// *** multi_io_flash_read_path.sv ***
// Serial flash front end for the dual and quad line read commands.
`timescale 1ns/1ps
`default_nettype none


module multi_io_flash_read_path #(
  parameter int ADDR_W = multi_io_pkg::ARRAY_ADDR_W
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire multi_io_pkg::spi_in_t pins_i,
  input wire logic quad_enable_bit_i,
  input wire logic load_we_i,
  input wire logic [ADDR_W-1:0] load_addr_i,
  input wire logic [7:0] load_data_i,
  output multi_io_pkg::spi_out_t pins_o,
  output logic cont_mode_o,
  output logic [2:0] wrap_setting_bits_o
);

  // --------------------------------------------------------------------------
  // Constants derived from the array size
  // --------------------------------------------------------------------------
  localparam logic [23:0] ARRAY_MASK = 24'((64'h1 << ADDR_W) - 64'h1);

  // --------------------------------------------------------------------------
  // State and helpers
  // --------------------------------------------------------------------------
  multi_io_pkg::flash_state_t q;
  multi_io_pkg::flash_state_t d;
  logic [7:0] mem_rdata;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;

  // Number of lines that carry address and mode bits for a read command.
  function automatic logic [2:0] in_lanes(input multi_io_pkg::read_cmd_t cmd);
    unique case (cmd)
      multi_io_pkg::CMD_QUAD_OUT: in_lanes = 3'h1;
      multi_io_pkg::CMD_DUAL_IO: in_lanes = 3'h2;
      multi_io_pkg::CMD_QUAD_IO: in_lanes = 3'h4;
      multi_io_pkg::CMD_QUAD_WORD: in_lanes = 3'h4;
    endcase
  endfunction : in_lanes

  // Address phase length in serial clocks.
  function automatic logic [5:0] addr_clocks(input multi_io_pkg::read_cmd_t cmd);
    unique case (cmd)
      multi_io_pkg::CMD_QUAD_OUT: addr_clocks = multi_io_pkg::SINGLE_ADDR_CLOCKS;
      multi_io_pkg::CMD_DUAL_IO: addr_clocks = multi_io_pkg::DUAL_ADDR_CLOCKS;
      multi_io_pkg::CMD_QUAD_IO: addr_clocks = multi_io_pkg::QUAD_ADDR_CLOCKS;
      multi_io_pkg::CMD_QUAD_WORD: addr_clocks = multi_io_pkg::QUAD_ADDR_CLOCKS;
    endcase
  endfunction : addr_clocks

  // Dummy phase length in serial clocks after the mode byte or address.
  function automatic logic [5:0] dummy_clocks(input multi_io_pkg::read_cmd_t cmd);
    unique case (cmd)
      multi_io_pkg::CMD_QUAD_OUT: dummy_clocks = multi_io_pkg::QUAD_OUT_DUMMY_CLOCKS;
      multi_io_pkg::CMD_DUAL_IO: dummy_clocks = 6'h00;
      multi_io_pkg::CMD_QUAD_IO: dummy_clocks = multi_io_pkg::QUAD_IO_DUMMY_CLOCKS;
      multi_io_pkg::CMD_QUAD_WORD: dummy_clocks = multi_io_pkg::QUAD_WORD_DUMMY_CLOCKS;
    endcase
  endfunction : dummy_clocks

  // Shifts the sampled lines into the low end of the collecting register.
  function automatic logic [23:0] shift_in(input logic [23:0] sr, input logic [3:0] io,
                                           input logic [2:0] lanes);
    unique case (lanes)
      3'h2: shift_in = {sr[21:0], io[1], io[0]};
      3'h4: shift_in = {sr[19:0], io};
      default: shift_in = {sr[22:0], io[0]};
    endcase
  endfunction : shift_in

  // Next byte address: section wrap for quad I/O and quad word reads when enabled, else array rollover.
  function automatic logic [23:0] next_addr(input logic [23:0] addr,
                                            input multi_io_pkg::read_cmd_t cmd,
                                            input logic [2:0] wrap);
    logic [23:0] wmask;
    wmask = {16'h0000, 8'((multi_io_pkg::WRAP_BASE_LEN << wrap[2:1]) - 8'h01)};
    if ((cmd == multi_io_pkg::CMD_QUAD_IO || cmd == multi_io_pkg::CMD_QUAD_WORD) &&
        !wrap[0]) begin
      next_addr = (addr & ~wmask) | ((addr + 24'h000001) & wmask);
    end else begin
      next_addr = (addr + 24'h000001) & ARRAY_MASK;
    end
  endfunction : next_addr

  // --------------------------------------------------------------------------
  // Pin edge detection on the synchronised pins
  // --------------------------------------------------------------------------
  // Only the second sync stage and its delayed copy are compared here.
  assign sclk_rise = q.sync2.sclk & ~q.prev.sclk;
  assign sclk_fall = ~q.sync2.sclk & q.prev.sclk;
  assign cs_fall = ~q.sync2.cs_n & q.prev.cs_n;

  // --------------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------------
  // Input bits are taken on serial clock rises, output bits change on falls.
  always_comb begin
    logic [23:0] sh_new;
    logic [5:0] cnt_new;
    logic [7:0] cur_byte;
    logic [7:0] mode_byte;
    sh_new = 24'h000000;
    cnt_new = 6'h00;
    cur_byte = 8'h00;
    mode_byte = 8'h00;
    d = q;
    d.sync1 = pins_i;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    if (q.sync2.cs_n) begin
      // A continuous-mode transaction that sees only ones on the address lines
      // before chip select rises is the mode reset sequence.
      if (q.phase == multi_io_pkg::PH_ADDR && q.skip && q.ones && q.cnt != 6'h00) begin
        d.cont = 1'b0;
      end
      d.phase = multi_io_pkg::PH_IDLE;
      d.pins = multi_io_pkg::PINS_RELEASED;
    end else if (cs_fall) begin
      d.cnt = 6'h00;
      d.shift = 24'h000000;
      d.ones = 1'b1;
      d.skip = q.cont;
      d.pins = multi_io_pkg::PINS_RELEASED;
      if (q.cont) begin
        d.cmd = q.cont_cmd;
        d.phase = multi_io_pkg::PH_ADDR;
      end else begin
        d.phase = multi_io_pkg::PH_OPCODE;
      end
    end else if (sclk_rise) begin
      cnt_new = q.cnt + 6'h01;
      unique case (q.phase)
        multi_io_pkg::PH_OPCODE: begin
          sh_new = shift_in(q.shift, q.sync2.io, 3'h1);
          d.shift = sh_new;
          d.cnt = cnt_new;
          if (cnt_new == multi_io_pkg::OPCODE_CLOCKS) begin
            d.cnt = 6'h00;
            d.shift = 24'h000000;
            d.phase = multi_io_pkg::PH_ADDR;
            unique case (sh_new[7:0])
              multi_io_pkg::OP_DUAL_IO_READ: begin
                d.cmd = multi_io_pkg::CMD_DUAL_IO;
              end
              multi_io_pkg::OP_QUAD_OUT_READ: begin
                d.cmd = multi_io_pkg::CMD_QUAD_OUT;
              end
              multi_io_pkg::OP_QUAD_IO_READ: begin
                d.cmd = multi_io_pkg::CMD_QUAD_IO;
                if (!quad_enable_bit_i) begin
                  d.phase = multi_io_pkg::PH_IGNORE;
                end
              end
              multi_io_pkg::OP_QUAD_IO_WORD_READ: begin
                d.cmd = multi_io_pkg::CMD_QUAD_WORD;
                if (!quad_enable_bit_i) begin
                  d.phase = multi_io_pkg::PH_IGNORE;
                end
              end
              multi_io_pkg::OP_SET_WRAP: begin
                d.phase = multi_io_pkg::PH_WRAP;
              end
              multi_io_pkg::OP_MODE_RESET: begin
                d.cont = 1'b0;
                d.phase = multi_io_pkg::PH_IGNORE;
              end
              default: begin
                d.phase = multi_io_pkg::PH_IGNORE;
              end
            endcase
          end
        end
        multi_io_pkg::PH_ADDR: begin
          sh_new = shift_in(q.shift, q.sync2.io, in_lanes(q.cmd));
          d.shift = sh_new;
          d.cnt = cnt_new;
          if ((in_lanes(q.cmd) == 3'h4 && q.sync2.io != 4'hf) ||
              (in_lanes(q.cmd) == 3'h2 && q.sync2.io[1:0] != 2'h3) ||
              (in_lanes(q.cmd) == 3'h1 && !q.sync2.io[0])) begin
            d.ones = 1'b0;
          end
          if (cnt_new == addr_clocks(q.cmd)) begin
            d.cnt = 6'h00;
            d.shift = 24'h000000;
            d.addr = sh_new & ARRAY_MASK;
            if (q.cmd == multi_io_pkg::CMD_QUAD_WORD) begin
              d.addr[0] = 1'b0;
            end
            if (q.cmd == multi_io_pkg::CMD_QUAD_OUT) begin
              d.phase = multi_io_pkg::PH_DUMMY;
            end else begin
              d.phase = multi_io_pkg::PH_MODE;
            end
          end
        end
        multi_io_pkg::PH_MODE: begin
          sh_new = shift_in(q.shift, q.sync2.io, in_lanes(q.cmd));
          d.shift = sh_new;
          d.cnt = cnt_new;
          if (cnt_new == (in_lanes(q.cmd) == 3'h2 ? multi_io_pkg::DUAL_MODE_CLOCKS :
                          multi_io_pkg::QUAD_MODE_CLOCKS)) begin
            mode_byte = sh_new[7:0];
            // Only the skip field decides; the low nibble is never looked at.
            d.cont = (mode_byte[multi_io_pkg::OPCODE_SKIP_LSB +: 2] ==
                      multi_io_pkg::OPCODE_SKIP_MATCH);
            d.cont_cmd = q.cmd;
            d.cnt = 6'h00;
            d.bits_left = 4'h0;
            if (dummy_clocks(q.cmd) == 6'h00) begin
              d.phase = multi_io_pkg::PH_DATA;
            end else begin
              d.phase = multi_io_pkg::PH_DUMMY;
            end
          end
        end
        multi_io_pkg::PH_DUMMY: begin
          d.cnt = cnt_new;
          if (cnt_new == dummy_clocks(q.cmd)) begin
            d.cnt = 6'h00;
            d.bits_left = 4'h0;
            d.phase = multi_io_pkg::PH_DATA;
          end
        end
        multi_io_pkg::PH_WRAP: begin
          sh_new = shift_in(q.shift, q.sync2.io, 3'h1);
          d.shift = sh_new;
          d.cnt = cnt_new;
          if (cnt_new == multi_io_pkg::WRAP_CMD_CLOCKS) begin
            d.wrap = sh_new[multi_io_pkg::WRAP_FIELD_LSB +: 3];
            d.phase = multi_io_pkg::PH_IGNORE;
          end
        end
        default: begin
          d.cnt = q.cnt;
        end
      endcase
    end else if (sclk_fall && q.phase == multi_io_pkg::PH_DATA) begin
      // The host has let go of the lines by this edge, so driving is safe.
      cur_byte = (q.bits_left == 4'h0) ? mem_rdata : q.byte_sr;
      if (q.bits_left == 4'h0) begin
        d.addr = next_addr(q.addr, q.cmd, q.wrap);
      end
      if (q.cmd == multi_io_pkg::CMD_DUAL_IO) begin
        d.pins.io = {2'h0, cur_byte[7], cur_byte[6]};
        d.pins.io_oe_n = 4'hc;
        d.byte_sr = {cur_byte[5:0], 2'h0};
        d.bits_left = ((q.bits_left == 4'h0) ? multi_io_pkg::BYTE_BITS : q.bits_left) - 4'h2;
      end else begin
        d.pins.io = cur_byte[7:4];
        d.pins.io_oe_n = 4'h0;
        d.byte_sr = {cur_byte[3:0], 4'h0};
        d.bits_left = ((q.bits_left == 4'h0) ? multi_io_pkg::BYTE_BITS : q.bits_left) - 4'h4;
      end
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= multi_io_pkg::STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Array and outputs
  // --------------------------------------------------------------------------
  // The read address follows the byte counter; data are ready a cycle later.
  flash_byte_array #(
    .ADDR_W(ADDR_W)
  ) u_array (
    .clock_i(clock_i),
    .we_i(load_we_i),
    .waddr_i(load_addr_i),
    .wdata_i(load_data_i),
    .raddr_i(q.addr[ADDR_W-1:0]),
    .rdata_o(mem_rdata)
  );

  // All outputs are fields of the state register.
  assign pins_o = q.pins;
  assign cont_mode_o = q.cont;
  assign wrap_setting_bits_o = q.wrap;

endmodule : multi_io_flash_read_path
`default_nettype wire

// *** multi_io_flash_read_path_bench.sv ***
// Self-checking bench for the multi-line flash read path.
`timescale 1ns/1ps
`default_nettype none

module multi_io_flash_read_path_bench;
  localparam int AW = 10;
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] mode;
  } row_t;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic qe = 1'b1;
  logic load_we = 1'b0;
  logic [AW-1:0] load_addr = 10'h000;
  logic [7:0] load_data = 8'h00;
  multi_io_pkg::spi_in_t pins_in;
  multi_io_pkg::spi_out_t pins_out;
  logic cont_mode;
  logic [2:0] wrap_bits;
  logic cont_exp = 1'b0;
  int drive_seen = 0;
  int drive_mark = 0;
  logic [3:0] v;
  logic [7:0] b;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  row_t rows [7] = '{
    '{8'hbb, 24'h000005, 8'h2f}, '{8'hbb, 24'h0003fe, 8'h1f},
    '{8'h6b, 24'h0000a1, 8'h00}, '{8'heb, 24'h0003ff, 8'ha0},
    '{8'heb, 24'h000010, 8'h00}, '{8'he7, 24'h000133, 8'h20},
    '{8'he7, 24'h000200, 8'hf0}};

  multi_io_flash_read_path #(.ADDR_W(AW)) multi_io_flash_read_path_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .pins_i(pins_in),
    .quad_enable_bit_i(qe), .load_we_i(load_we), .load_addr_i(load_addr),
    .load_data_i(load_data), .pins_o(pins_out), .cont_mode_o(cont_mode),
    .wrap_setting_bits_o(wrap_bits));
  spi_host spi_host_i (.clock_i(clock_i), .dev_i(pins_out), .pins_o(pins_in));

  // The clock toggles every half period; cycles and driven-line cycles are counted.
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (pins_out.io_oe_n !== 4'hf) drive_seen++;
  end

  // Byte stored at each array address, distinct across the four pages.
  function automatic logic [7:0] pat(input logic [AW-1:0] a);
    return a[7:0] ^ {4{a[9:8]}};
  endfunction : pat

  // Address after one byte, optionally held inside an aligned section.
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] a, input int len);
    if (len == 0) return a + 10'h001;
    return (a & ~AW'(len - 1)) | ((a + 10'h001) & AW'(len - 1));
  endfunction : nxt

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic hold_reset();
    rst_n_i = 1'b0;
    repeat (20) @(negedge clock_i);
    chk("oe_n in reset", 4'hf, pins_out.io_oe_n);
    chk("mode in reset", 1'b0, cont_mode);
    chk("wrap in reset", 3'h1, wrap_bits);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
  endtask : hold_reset

  task automatic send_op(input logic [7:0] op);
    for (int i = 7; i >= 0; i--) begin
      spi_host_i.shift({3'h0, op[i]}, 4'h1, 1'b0);
    end
  endtask : send_op

  task automatic put(input logic [31:0] w32, input int w, input bit rel);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    for (int i = 32 / w - 1; i >= 0; i--) begin
      spi_host_i.shift(4'(w32 >> (i * w)) & m, m, rel && i == 0);
    end
  endtask : put

  task automatic dummy(input int n);
    for (int i = n - 1; i >= 0; i--) begin
      spi_host_i.shift(4'hf, 4'hf, i == 0);
    end
  endtask : dummy

  task automatic get(input int w, output logic [7:0] d);
    logic [3:0] s;
    d = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      spi_host_i.sample(s);
      d = (d << w) | 8'(s & 4'((1 << w) - 1));
    end
  endtask : get

  task automatic set_wrap(input logic [7:0] wb);
    spi_host_i.open_frame();
    send_op(8'h77);
    put({24'h000000, wb}, 1, 1'b0);
    spi_host_i.close_frame();
  endtask : set_wrap

  // One whole read frame, checking each byte and the stored mode.
  task automatic read(input row_t r, input int n, input int len);
    int w;
    int dm;
    logic [AW-1:0] a;
    logic [7:0] d;
    w = r.op == 8'hbb ? 2 : r.op == 8'h6b ? 1 : 4;
    dm = r.op == 8'heb ? 4 : r.op == 8'he7 ? 2 : 0;
    a = r.addr[AW-1:0] & ~{9'h000, r.op == 8'he7};
    spi_host_i.open_frame();
    if (!cont_exp) send_op(r.op);
    if (w == 1) put({r.addr, 8'hff}, 1, 1'b1);
    else put({r.addr, r.mode}, w, dm == 0);
    dummy(dm);
    for (int i = 0; i < n; i++) begin
      get(w == 2 ? 2 : 4, d);
      chk("read byte", pat(a), d);
      a = nxt(a, len);
    end
    spi_host_i.close_frame();
    if (w > 1) cont_exp = r.mode[5:4] == 2'h2;
    chk("continuous mode", cont_exp, cont_mode);
  endtask : read

  // Table rows first, then wrap, refusal, abort and mode reset cases.
  task automatic run_tests();
    hold_reset();
    for (int a = 0; a < 1024; a++) begin
      @(negedge clock_i);
      load_we = 1'b1;
      load_addr = 10'(a);
      load_data = pat(10'(a));
    end
    @(negedge clock_i);
    load_we = 1'b0;
    foreach (rows[i]) begin
      read(rows[i], 3, 0);
    end
    for (int c = 0; c < 4; c++) begin
      set_wrap({1'b0, 2'(c), 5'h00});
      chk("wrap bits", {2'(c), 1'b0}, wrap_bits);
      read('{c[0] ? 8'he7 : 8'heb, 24'(10'h100 + (8 << c) - 2), 8'h00}, 3, 8 << c);
    end
    hold_reset();
    set_wrap(8'h20);
    chk("wrap bits", 3'h2, wrap_bits);
    set_wrap(8'h10);
    chk("wrap bits", 3'h1, wrap_bits);
    read('{8'heb, 24'h00011e, 8'h00}, 3, 0);
    for (int k = 0; k < 3; k++) begin
      qe = 1'b0;
      drive_mark = drive_seen;
      spi_host_i.open_frame();
      send_op(k == 0 ? 8'heb : k == 1 ? 8'he7 : 8'h00);
      put({24'h000040, 8'h20}, 4, 1'b0);
      dummy(4);
      get(4, b);
      spi_host_i.close_frame();
      chk("lines driven when refused", 24'(drive_mark), 24'(drive_seen));
      chk("mode after refused read", 1'b0, cont_mode);
    end
    qe = 1'b1;
    spi_host_i.open_frame();
    send_op(8'hbb);
    put({24'h0000c7, 8'h00}, 2, 1'b1);
    spi_host_i.sample(v);
    chk("dual lane drive", 4'hc, pins_out.io_oe_n);
    chk("first pair", pat(10'h0c7) >> 6, v[1:0]);
    spi_host_i.close_frame();
    chk("released after abort", 4'hf, pins_out.io_oe_n);
    read('{8'hbb, 24'h000020, 8'h20}, 1, 0);
    spi_host_i.open_frame();
    send_op(8'hff);
    spi_host_i.close_frame();
    cont_exp = 1'b0;
    chk("mode after reset command", 1'b0, cont_mode);
    read('{8'h6b, 24'h000031, 8'h00}, 2, 0);
  endtask : run_tests

  // Runs the tests against the cycle limit; a hang counts as a mismatch.
  initial begin
    fork
      run_tests();
      begin
        wait (cycles == 30000);
        fails++;
      end
    join_any
    summarize();
  end
endmodule : multi_io_flash_read_path_bench

bind multi_io_flash_read_path flash_read_monitor flash_read_monitor_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .pins_i(pins_i), .pins_o(pins_o),
  .cont_mode_o(cont_mode_o), .wrap_setting_bits_o(wrap_setting_bits_o));
`default_nettype wire

// *** multi_io_pkg.sv ***
// Shared constants, types and reset values for the multi-line flash read path.
package multi_io_pkg;

  // --------------------------------------------------------------------------
  // Command codes
  // --------------------------------------------------------------------------
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] OP_QUAD_IO_WORD_READ = 8'he7;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_MODE_RESET = 8'hff;

  // --------------------------------------------------------------------------
  // Array geometry and phase lengths, in serial clocks
  // --------------------------------------------------------------------------
  localparam int ARRAY_ADDR_W = 22;
  localparam logic [5:0] OPCODE_CLOCKS = 6'h08;
  localparam logic [5:0] SINGLE_ADDR_CLOCKS = 6'h18;
  localparam logic [5:0] DUAL_ADDR_CLOCKS = 6'h0c;
  localparam logic [5:0] QUAD_ADDR_CLOCKS = 6'h06;
  localparam logic [5:0] DUAL_MODE_CLOCKS = 6'h04;
  localparam logic [5:0] QUAD_MODE_CLOCKS = 6'h02;
  localparam logic [5:0] QUAD_OUT_DUMMY_CLOCKS = 6'h08;
  localparam logic [5:0] QUAD_IO_DUMMY_CLOCKS = 6'h04;
  localparam logic [5:0] QUAD_WORD_DUMMY_CLOCKS = 6'h02;
  localparam logic [5:0] WRAP_CMD_CLOCKS = 6'h20;

  // --------------------------------------------------------------------------
  // Mode byte and wrap setting fields
  // --------------------------------------------------------------------------
  localparam int OPCODE_SKIP_LSB = 4;
  localparam logic [1:0] OPCODE_SKIP_MATCH = 2'h2;
  localparam int WRAP_FIELD_LSB = 4;
  localparam logic [2:0] WRAP_SETTING_RESET = 3'h1;
  localparam logic [7:0] WRAP_BASE_LEN = 8'h08;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE, PH_OPCODE, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA, PH_WRAP, PH_IGNORE
  } phase_t;

  typedef enum logic [1:0] {
    CMD_DUAL_IO, CMD_QUAD_OUT, CMD_QUAD_IO, CMD_QUAD_WORD
  } read_cmd_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] io;
  } spi_in_t;

  typedef struct packed {
    logic [3:0] io;
    logic [3:0] io_oe_n;
  } spi_out_t;

  typedef struct packed {
    spi_in_t sync1;
    spi_in_t sync2;
    spi_in_t prev;
    phase_t phase;
    read_cmd_t cmd;
    logic [5:0] cnt;
    logic [23:0] shift;
    logic [23:0] addr;
    logic [7:0] byte_sr;
    logic [3:0] bits_left;
    logic skip;
    logic ones;
    logic cont;
    read_cmd_t cont_cmd;
    logic [2:0] wrap;
    spi_out_t pins;
  } flash_state_t;

  localparam spi_in_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, io: 4'hf};
  localparam spi_out_t PINS_RELEASED = '{io: 4'h0, io_oe_n: 4'hf};

  localparam flash_state_t STATE_RESET = '{
    sync1: PINS_IDLE, sync2: PINS_IDLE, prev: PINS_IDLE,
    phase: PH_IDLE, cmd: CMD_DUAL_IO, cnt: 6'h00, shift: 24'h000000,
    addr: 24'h000000, byte_sr: 8'h00, bits_left: 4'h0, skip: 1'b0,
    ones: 1'b0, cont: 1'b0, cont_cmd: CMD_DUAL_IO,
    wrap: WRAP_SETTING_RESET, pins: PINS_RELEASED
  };

endpackage : multi_io_pkg

// *** spi_host.sv ***
// Behavioural SPI host that frames commands and clocks the data lines.
`timescale 1ns/1ps
`default_nettype none

module spi_host (
  input wire logic clock_i,
  input wire multi_io_pkg::spi_out_t dev_i,
  output wire multi_io_pkg::spi_in_t pins_o
);
  logic sclk_q = 1'b0;
  logic cs_n_q = 1'b1;
  logic [3:0] drive_q = 4'h0;
  logic [3:0] en_q = 4'h0;
  logic [3:0] line;

  // Each line follows the device, else the host, else its pull-up.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      line[k] = !dev_i.io_oe_n[k] ? dev_i.io[k] : (en_q[k] ? drive_q[k] : 1'b1);
    end
  end
  assign pins_o = '{sclk: sclk_q, cs_n: cs_n_q, io: line};

  // Selects the device; the clock stays low outside frames.
  task automatic open_frame();
    @(negedge clock_i);
    cs_n_q = 1'b0;
    repeat (4) @(negedge clock_i);
  endtask : open_frame

  // Drives one clock on the enabled lanes, releasing them before the fall when rel is set.
  task automatic shift(input logic [3:0] v, input logic [3:0] en, input bit rel);
    drive_q = v;
    en_q = en;
    repeat (4) @(negedge clock_i);
    sclk_q = 1'b1;
    repeat (3) @(negedge clock_i);
    if (rel) en_q = 4'h0;
    @(negedge clock_i);
    sclk_q = 1'b0;
  endtask : shift

  // Clocks one data cycle with every host driver off.
  task automatic sample(output logic [3:0] v);
    en_q = 4'h0;
    repeat (4) @(negedge clock_i);
    v = line;
    sclk_q = 1'b1;
    repeat (4) @(negedge clock_i);
    sclk_q = 1'b0;
  endtask : sample

  // Ends the frame and keeps chip select high before the next one.
  task automatic close_frame();
    @(negedge clock_i);
    cs_n_q = 1'b1;
    en_q = 4'h0;
    repeat (4) @(negedge clock_i);
  endtask : close_frame
endmodule : spi_host
`default_nettype wire
